// file: src/smic_ctrl.sv
/*
 * Slave-mode interrupt controller with AHB-Lite register slave.
 * Assumes source request, nonmaskable, return and acknowledge pulses come from
 * logic on mclk_i, and that the bus master issues single word transfers.
 */
// The AHB-Lite register port was left to the implementer.
// Overview of operation
// - DMA-halt flag high stops all DMA channel activity.
// - Nonmaskable event sets DMA-halt; interrupt return clears it.
// - Status low three bits show timer 2, 1, 0 pending requests.
// - Request bit sets on source request, clears on internal acknowledge.
// - Request register read-only: T2 bit5, T1 bit4, DMA bits3-2, T0 bit0.
// - Taking an interrupt sets its in-service bit, same bit layout.
// - In-service bits clear only by end-of-interrupt writes.
// - Unmasked source raises interrupt only if priority not above threshold.
// - Threshold 111b admits all; 101b admits priorities 000b to 101b.
// - Threshold resets to 0007h.
// - Mask register and control mask bits share one state.
// - Mask register resets to 003Dh, reserved bit 1 zero.
// - End-of-interrupt write clears in-service bit with matching priority.
// - End-of-interrupt register is write-only, no reset value.
// - Type is vector bits 7-3 above acknowledged priority level.
// - Processor shifts type left two bits for table offset.
// - Vector reserved upper byte and low three bits read zero.
// - Status, request and in-service clear to zero on reset.
// - Starts in master operation; relocation bit 14 selects slave.
// - After acknowledge, only equal or higher priority may nest.
// - Control registers: mask bit 3, priority bits 2-0, reset 000Fh.

`timescale 1ns/100ps

module smic_ctrl (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic srst_i,
    // AHB-Lite slave.
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic hreadyout_o,
    output logic hresp_o,
    output logic [31:0] hrdata_o,
    // Source request pulses, same slot layout as the request register.
    input wire logic [5:0] src_req_i,
    // Processor events.
    input wire logic nmi_i,
    input wire logic iret_i,
    input wire logic inta_i,
    // Interrupt delivery to the master controller.
    output logic int_o,
    output logic [7:0] int_type_o,
    output logic [9:0] vector_offset_o,
    // DMA halt.
    output logic dma_halt_o
);

    ////////////////////////////////////////////////////////////////////////////////
    // State and arbitration signals.

    smic_pkg::smic_state_t st;
    smic_pkg::smic_state_t next_st;
    logic [5:0] eligible;
    logic [2:0] best_prio;
    logic [5:0] best_onehot;
    logic any_eligible;
    logic [2:0] isr_floor;
    logic isr_any;

    ////////////////////////////////////////////////////////////////////////////////
    // Per-source eligibility.

    // Lowest numeric priority currently in service bounds the nesting level.
    always_comb begin
        isr_any = 1'b0;
        isr_floor = 3'h7;
        for (int i = 0; i < smic_pkg::NUM_SLOTS; i++) begin
            if (st.isr[i] && smic_pkg::SRC_VALID[i]) begin
                if (!isr_any || st.prio[3*i +: 3] < isr_floor) begin
                    isr_floor = st.prio[3*i +: 3];
                end
                isr_any = 1'b1;
            end
        end
    end

    // A slot may interrupt when pending, unmasked, admitted and not nested out.
    genvar g;
    generate
        for (g = 0; g < smic_pkg::NUM_SLOTS; g++) begin : gen_slot
            if (smic_pkg::SRC_VALID[g]) begin : gen_used
                assign eligible[g] = st.req[g] && !st.mask[g]
                    && (st.prio[3*g +: 3] <= st.thresh)
                    && (!isr_any || st.prio[3*g +: 3] <= isr_floor);
            end else begin : gen_rsvd
                assign eligible[g] = 1'b0;
            end
        end
    endgenerate

    // Pick the eligible slot with the numerically lowest priority value.
    always_comb begin
        any_eligible = 1'b0;
        best_prio = 3'h7;
        best_onehot = 6'h00;
        for (int i = 0; i < smic_pkg::NUM_SLOTS; i++) begin
            if (eligible[i] && (!any_eligible || st.prio[3*i +: 3] < best_prio)) begin
                best_prio = st.prio[3*i +: 3];
                best_onehot = 6'h00;
                best_onehot[i] = 1'b1;
                any_eligible = 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Register read mux.

    // Returns the read value of a register index; write-only and unmapped read zero.
    function automatic logic [15:0] read_reg(input smic_pkg::smic_state_t s,
                                             input logic [7:0] idx);
        logic [15:0] v;
        v = 16'h0000;
        case (idx)
            smic_pkg::IDX_VECTOR_BASE: begin
                v[7:3] = s.vec;
            end
            smic_pkg::IDX_SOURCE_MASK: begin
                v[5:0] = s.mask & smic_pkg::SRC_VALID;
            end
            smic_pkg::IDX_PRIO_THRESH: begin
                v[2:0] = s.thresh;
            end
            smic_pkg::IDX_IN_SERVICE: begin
                v[5:0] = s.isr & smic_pkg::SRC_VALID;
            end
            smic_pkg::IDX_REQ_PENDING: begin
                v[5:0] = s.req & smic_pkg::SRC_VALID;
            end
            smic_pkg::IDX_INT_STATUS: begin
                v[smic_pkg::STS_HALT_BIT] = s.dma_halt;
                v[2:0] = {s.req[smic_pkg::SRC_TMR2], s.req[smic_pkg::SRC_TMR1],
                          s.req[smic_pkg::SRC_TMR0]};
            end
            smic_pkg::IDX_CTL_TMR0: begin
                v[3:0] = {s.mask[smic_pkg::SRC_TMR0], s.prio[3*smic_pkg::SRC_TMR0 +: 3]};
            end
            smic_pkg::IDX_CTL_DMA0: begin
                v[3:0] = {s.mask[smic_pkg::SRC_DMA0], s.prio[3*smic_pkg::SRC_DMA0 +: 3]};
            end
            smic_pkg::IDX_CTL_DMA1: begin
                v[3:0] = {s.mask[smic_pkg::SRC_DMA1], s.prio[3*smic_pkg::SRC_DMA1 +: 3]};
            end
            smic_pkg::IDX_CTL_TMR1: begin
                v[3:0] = {s.mask[smic_pkg::SRC_TMR1], s.prio[3*smic_pkg::SRC_TMR1 +: 3]};
            end
            smic_pkg::IDX_CTL_TMR2: begin
                v[3:0] = {s.mask[smic_pkg::SRC_TMR2], s.prio[3*smic_pkg::SRC_TMR2 +: 3]};
            end
            smic_pkg::IDX_RELOCATION: begin
                v[smic_pkg::RELOC_SLAVE_BIT] = s.slave;
            end
            default: begin
                v = 16'h0000;
            end
        endcase
        return v;
    endfunction

    // Maps a control register index to its source slot, or -1 when none.
    function automatic int ctl_slot(input logic [7:0] idx);
        int n;
        n = -1;
        case (idx)
            smic_pkg::IDX_CTL_TMR0: n = smic_pkg::SRC_TMR0;
            smic_pkg::IDX_CTL_DMA0: n = smic_pkg::SRC_DMA0;
            smic_pkg::IDX_CTL_DMA1: n = smic_pkg::SRC_DMA1;
            smic_pkg::IDX_CTL_TMR1: n = smic_pkg::SRC_TMR1;
            smic_pkg::IDX_CTL_TMR2: n = smic_pkg::SRC_TMR2;
            default: n = -1;
        endcase
        return n;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Next-state logic.

    // Bus writes first, then hardware events, so hardware events win and among them a set wins over a clear.
    always_comb begin
        logic addr_ok;
        logic [15:0] wd;
        logic [5:0] eoi_clr;
        logic do_ack;
        int slot;
        addr_ok = 1'b0;
        wd = 16'h0000;
        eoi_clr = 6'h00;
        do_ack = 1'b0;
        slot = -1;
        next_st = st;
        wd = hwdata_i[15:0];
        // Data phase of a write.
        if (st.wr_pend) begin
            slot = ctl_slot(st.wr_idx);
            case (st.wr_idx)
                smic_pkg::IDX_VECTOR_BASE: begin
                    next_st.vec = wd[7:3];
                end
                smic_pkg::IDX_EOI_CMD: begin
                    for (int i = 0; i < smic_pkg::NUM_SLOTS; i++) begin
                        if (st.prio[3*i +: 3] == wd[2:0]) begin
                            eoi_clr[i] = 1'b1;
                        end
                    end
                end
                smic_pkg::IDX_SOURCE_MASK: begin
                    next_st.mask = wd[5:0] & smic_pkg::SRC_VALID;
                end
                smic_pkg::IDX_PRIO_THRESH: begin
                    next_st.thresh = wd[2:0];
                end
                smic_pkg::IDX_INT_STATUS: begin
                    next_st.dma_halt = wd[smic_pkg::STS_HALT_BIT];
                end
                smic_pkg::IDX_RELOCATION: begin
                    next_st.slave = wd[smic_pkg::RELOC_SLAVE_BIT];
                end
                default: begin
                    if (slot >= 0) begin
                        next_st.mask[slot] = wd[smic_pkg::CTL_MASK_BIT];
                        next_st.prio[3*slot +: 3] = wd[2:0];
                    end
                end
            endcase
            next_st.wr_pend = 1'b0;
        end
        // Address phase: capture a write, or stage read data for the data phase.
        addr_ok = hsel_i && hready_i && htrans_i[1];
        if (addr_ok && hwrite_i) begin
            next_st.wr_pend = 1'b1;
            next_st.wr_idx = haddr_i[9:2];
        end
        if (addr_ok && !hwrite_i) begin
            next_st.rdata = {16'h0000, read_reg(st, haddr_i[9:2])};
        end
        // End-of-interrupt clears only; acknowledge never clears in-service.
        next_st.isr = st.isr & ~eoi_clr;
        // Acknowledge takes the presented request.
        do_ack = inta_i && st.slave && any_eligible;
        if (do_ack) begin
            next_st.req = st.req & ~best_onehot;
            next_st.isr = next_st.isr | best_onehot;
            next_st.int_type = {st.vec, best_prio};
        end
        // New source requests win over the acknowledge clear.
        next_st.req = next_st.req | (src_req_i & smic_pkg::SRC_VALID);
        // Return clears the halt; a coincident nonmaskable event wins.
        if (iret_i) begin
            next_st.dma_halt = 1'b0;
        end
        if (nmi_i) begin
            next_st.dma_halt = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // State register.

    // Synchronous reset loads documented reset values.
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            st.slave <= 1'b0;
            st.dma_halt <= 1'b0;
            st.req <= 6'h00;
            st.isr <= 6'h00;
            st.mask <= smic_pkg::RST_MASK;
            st.prio <= {smic_pkg::NUM_SLOTS{smic_pkg::RST_PRIO}};
            st.thresh <= smic_pkg::RST_THRESH;
            st.vec <= 5'h00;
            st.int_type <= 8'h00;
            st.wr_pend <= 1'b0;
            st.wr_idx <= 8'h00;
            st.rdata <= 32'h00000000;
        end else begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs.

    // Zero-wait slave, always OKAY.
    assign hreadyout_o = 1'b1;
    assign hresp_o = smic_pkg::HRESP_OKAY;
    assign hrdata_o = st.rdata;

    // Request line is live only in slave operation.
    assign int_o = st.slave && any_eligible;
    assign int_type_o = st.int_type;
    assign vector_offset_o = {st.int_type, 2'h0};
    assign dma_halt_o = st.dma_halt;

endmodule

// file: src/smic_pkg.sv
/*
 * Constants and types for the slave-mode interrupt controller.
 * Assumes a 32-bit AHB-Lite register bus; each register index maps to byte address index*4.
 */
package smic_pkg;

    // Register indices; byte address is four times the index.
    localparam logic [7:0] IDX_VECTOR_BASE = 8'h20;
    localparam logic [7:0] IDX_EOI_CMD = 8'h22;
    localparam logic [7:0] IDX_SOURCE_MASK = 8'h28;
    localparam logic [7:0] IDX_PRIO_THRESH = 8'h2A;
    localparam logic [7:0] IDX_IN_SERVICE = 8'h2C;
    localparam logic [7:0] IDX_REQ_PENDING = 8'h2E;
    localparam logic [7:0] IDX_INT_STATUS = 8'h30;
    localparam logic [7:0] IDX_CTL_TMR0 = 8'h32;
    localparam logic [7:0] IDX_CTL_DMA0 = 8'h34;
    localparam logic [7:0] IDX_CTL_DMA1 = 8'h36;
    localparam logic [7:0] IDX_CTL_TMR1 = 8'h38;
    localparam logic [7:0] IDX_CTL_TMR2 = 8'h3A;
    localparam logic [7:0] IDX_RELOCATION = 8'h40;

    // Source bit positions in request, in-service and mask vectors.
    localparam int SRC_TMR0 = 0;
    localparam int SRC_DMA0 = 2;
    localparam int SRC_DMA1 = 3;
    localparam int SRC_TMR1 = 4;
    localparam int SRC_TMR2 = 5;
    localparam int NUM_SLOTS = 6;
    localparam logic [5:0] SRC_VALID = 6'h3D;

    // Field positions.
    localparam int STS_HALT_BIT = 15;
    localparam int CTL_MASK_BIT = 3;
    localparam int RELOC_SLAVE_BIT = 14;
    localparam int VEC_UPPER_LSB = 3;

    // Reset values.
    localparam logic [5:0] RST_MASK = 6'h3D;
    localparam logic [2:0] RST_THRESH = 3'h7;
    localparam logic [2:0] RST_PRIO = 3'h7;
    localparam logic [15:0] RST_CTL = 16'h000F;

    // AHB-Lite encodings.
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'h0;

    // Full controller state, registered as one word.
    typedef struct packed {
        logic slave;
        logic dma_halt;
        logic [5:0] req;
        logic [5:0] isr;
        logic [5:0] mask;
        logic [17:0] prio;
        logic [2:0] thresh;
        logic [4:0] vec;
        logic [7:0] int_type;
        logic wr_pend;
        logic [7:0] wr_idx;
        logic [31:0] rdata;
    } smic_state_t;

endpackage

// file: tb/smic_monitor.sv
/* Port checker for the slave interrupt controller.
   Assumes it is bound onto smic_ctrl with one clock domain. */
`timescale 1ns/100ps
module smic_monitor (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic srst_i,
    // Watched ports.
    input wire logic nmi_i,
    input wire logic iret_i,
    input wire logic inta_i,
    input wire logic hreadyout_o,
    input wire logic hresp_o,
    input wire logic int_o,
    input wire logic [7:0] int_type_o,
    input wire logic [9:0] vector_offset_o,
    input wire logic dma_halt_o
);
    // All checks sample on the clock and pause in reset.
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (srst_i);
    a_bus_ready: assert property (hreadyout_o)
        else $error("bus wait state");
    a_bus_okay: assert property (!hresp_o)
        else $error("bus response not okay");
    a_offset_shift: assert property (vector_offset_o == {int_type_o, 2'h0})
        else $error("offset is not type times four");
    a_nmi_halt: assert property (nmi_i |=> dma_halt_o)
        else $error("halt not set");
    a_nmi_wins: assert property (nmi_i && iret_i |=> dma_halt_o ##1 dma_halt_o)
        else $error("halt lost on joint event");
    a_iret_release: assert property (iret_i && !nmi_i |=> !dma_halt_o)
        else $error("halt not cleared");
    a_type_hold: assert property (!(inta_i && int_o) |=> $stable(int_type_o))
        else $error("type moved without acknowledge");
    a_start_master: assert property ($fell(srst_i) |-> !int_o && !dma_halt_o)
        else $error("active after reset");
    // Main traffic seen.
    c_ack: cover property (inta_i && int_o);
    c_halt: cover property (nmi_i);
    c_release: cover property ($fell(dma_halt_o));
endmodule
////////////////////////////////////////
bind smic_ctrl smic_monitor mon_u (.mclk_i(mclk_i), .srst_i(srst_i), .nmi_i(nmi_i),
    .iret_i(iret_i), .inta_i(inta_i), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .int_o(int_o), .int_type_o(int_type_o), .vector_offset_o(vector_offset_o),
    .dma_halt_o(dma_halt_o));

// file: tb/smic_cpu_model.sv
/* Model of the processor and master controller above the slave controller.
   Assumes int_i comes from the controller on the same clock. */
`timescale 1ns/100ps
module smic_cpu_model (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic srst_i,
    // Bench controls.
    input wire logic ack_en_i,
    input wire logic nmi_req_i,
    input wire logic iret_req_i,
    // Controller side.
    input wire logic int_i,
    output logic inta_o,
    output logic nmi_o,
    output logic iret_o,
    output logic [7:0] ack_cnt_o
);
    logic [1:0] gap;
    // Acknowledges a raised request after a varying gap, one pulse at a time.
    always_ff @(posedge mclk_i) begin
        nmi_o <= nmi_req_i;
        iret_o <= iret_req_i;
        inta_o <= 1'h0;
        if (srst_i) begin
            gap <= 2'h0;
            ack_cnt_o <= 8'h00;
        end else if (inta_o) begin
            gap <= ack_cnt_o[1:0];
        end else if (gap != 2'h0) begin
            gap <= gap - 2'h1;
        end else if (int_i && ack_en_i) begin
            inta_o <= 1'h1;
            ack_cnt_o <= ack_cnt_o + 8'h01;
        end
    end
endmodule

// file: tb/slave_mode_interrupt_controller_tb.sv
/* Self-checking bench for the slave interrupt controller.
   Assumes smic_ctrl, the processor model and the bound checker. */
`timescale 1ns/100ps
module slave_mode_interrupt_controller_tb;
    logic mclk = 1'h0, srst = 1'h1, hsel = 1'h0, hwrite = 1'h0, ack_en = 1'h0;
    logic nmi_req = 1'h0, iret_req = 1'h0;
    logic [1:0] htrans = 2'h0;
    logic [5:0] src_req = 6'h00;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rdat, vec;
    logic hready, hresp, int_w, inta, nmi, iret, dhalt;
    logic [7:0] itype, ack_cnt;
    int num_errors = 0, cmp_count = 0, seed = 32'h5AA5, m_req, m_isr, m_mask, m_thr, lp;
    int prio[6] = '{3, 0, 1, 4, 2, 6};
    int ca[6] = '{32'hC8, 0, 32'hD0, 32'hD8, 32'hE0, 32'hE8};
    int ra[9] = '{32'hA0, 32'hA8, 32'hB0, 32'hB8, 32'hC0, 32'hC8, 32'h88, 32'h80, 32'hFC};
    int re[9] = '{32'h3D, 32'h7, 0, 0, 0, 32'hF, 0, 0, 0};
    int thr[6] = '{3, 3, 3, 5, 5, 7};
    int nst[3] = '{5, 2, 0};

    smic_ctrl dut_u (.mclk_i(mclk), .srst_i(srst), .hsel_i(hsel), .haddr_i(haddr),
        .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
        .hready_i(hready), .hreadyout_o(hready), .hresp_o(hresp), .hrdata_o(hrdata),
        .src_req_i(src_req), .nmi_i(nmi), .iret_i(iret), .inta_i(inta), .int_o(int_w),
        .int_type_o(itype), .vector_offset_o(), .dma_halt_o(dhalt));
    smic_cpu_model cpu_u (.mclk_i(mclk), .srst_i(srst), .ack_en_i(ack_en),
        .nmi_req_i(nmi_req), .iret_req_i(iret_req), .int_i(int_w), .inta_o(inta),
        .nmi_o(nmi), .iret_o(iret), .ack_cnt_o(ack_cnt));

    ////////////////////////////////////////
    // Clock at 125 MHz.
    initial begin
        forever #4 mclk = ~mclk;
    end

    // Compares one result and counts it.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One single AHB-Lite word transfer; random upper write bits are ignored.
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd);
        hsel <= 1'h1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        @(posedge mclk);
        while (hready !== 1'h1) @(posedge mclk);
        htrans <= 2'h0;
        hwdata <= wd | ($random(seed) & 32'hFFFF0000);
        @(posedge mclk);
        while (hready !== 1'h1) @(posedge mclk);
        rdat = hrdata;
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        bus(1'h0, a, 32'h0);
        chk(rdat, e);
    endtask

    // Model choice: lowest priority value among eligible, unnested sources.
    function automatic int pick();
        int b, lim;
        b = -1;
        lim = 8;
        for (int s = 0; s < 6; s++) if (m_isr[s] && prio[s] < lim) lim = prio[s];
        for (int s = 0; s < 6; s++) begin
            if (s != 1 && m_req[s] && !m_mask[s] && prio[s] <= m_thr && prio[s] <= lim &&
                (b < 0 || prio[s] < prio[b])) b = s;
        end
        return b;
    endfunction

    // Waits for an acknowledge, or its absence, and checks the outcome.
    task automatic serve();
        int s, n, k;
        s = pick();
        n = ack_cnt;
        k = 0;
        while (ack_cnt == n && k < 40) begin
            @(posedge mclk);
            k++;
        end
        repeat (2) @(posedge mclk);
        if (s < 0) begin
            chk(32'(ack_cnt), n);
        end else begin
            m_req[s] = 0;
            m_isr[s] = 1;
            lp = prio[s];
            chk(32'(itype), {24'h0, vec[7:3], 3'(prio[s])});
            rd(32'hB0, m_isr);
            rd(32'hB8, m_req);
        end
    endtask

    task automatic end_sim();
        if (num_errors == 0 && cmp_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // Cuts a hang short.
    initial begin
        repeat (20000) @(posedge mclk);
        num_errors++;
        end_sim();
    end

    // Main sequence.
    initial begin
        repeat (8) @(posedge mclk);
        srst <= 1'h0;
        bus(1'h1, 32'hFC, 32'hFFFF);
        for (int i = 0; i < 9; i++) rd(ra[i], re[i]);
        for (int s = 0; s < 6; s++) if (s != 1) bus(1'h1, ca[s], prio[s]);
        rd(32'hA0, 32'h0);
        bus(1'h1, 32'hA0, 32'h3D);
        rd(32'hE0, 32'hA);
        bus(1'h1, 32'h100, 32'h4000);
        vec = $random(seed);
        bus(1'h1, 32'h80, vec);
        rd(32'h80, vec & 32'hF8);
        src_req <= 6'h3F;
        @(posedge mclk);
        src_req <= 6'h00;
        m_req = 32'h3D;
        m_isr = 0;
        m_mask = 32'h3D;
        rd(32'hB8, 32'h3D);
        chk(32'(int_w), 32'h0);
        nmi_req <= 1'h1;
        @(posedge mclk);
        nmi_req <= 1'h0;
        repeat (3) @(posedge mclk);
        rd(32'hC0, 32'h8007);
        nmi_req <= 1'h1;
        iret_req <= 1'h1;
        @(posedge mclk);
        nmi_req <= 1'h0;
        iret_req <= 1'h0;
        repeat (3) @(posedge mclk);
        chk(32'(dhalt), 32'h1);
        iret_req <= 1'h1;
        @(posedge mclk);
        iret_req <= 1'h0;
        repeat (3) @(posedge mclk);
        rd(32'hC0, 32'h7);
        // Software may raise the halt; the timer bits stay read-only.
        bus(1'h1, 32'hC0, 32'h8000);
        rd(32'hC0, 32'h8007);
        bus(1'h1, 32'hC0, 32'h0);
        bus(1'h1, 32'hA0, 32'h0);
        m_mask = 0;
        ack_en <= 1'h1;
        for (int i = 0; i < 6; i++) begin
            m_thr = thr[i];
            bus(1'h1, 32'hA8, m_thr);
            serve();
            serve();
            bus(1'h1, 32'h88, lp);
            for (int s = 0; s < 6; s++) if (prio[s] == lp) m_isr[s] = 0;
            rd(32'hB0, m_isr);
        end
        // Nesting: a higher priority source breaks into a lower one in service.
        for (int j = 0; j < 4; j++) begin
            if (j == 3) begin
                bus(1'h1, 32'h88, 32'h1);
                m_isr[2] = 0;
            end else begin
                src_req <= 6'h01 << nst[j];
                @(posedge mclk);
                src_req <= 6'h00;
                m_req[nst[j]] = 1;
            end
            serve();
        end
        end_sim();
    end
endmodule
